// ===== verilog/sslp_pkg.sv
// shared constants and types for the sram sleep control ends
package sslp_pkg;
  localparam int unsigned REF_CLK_MHZ         = 200;
  localparam int unsigned ADDR_W              = 4;
  localparam int unsigned DATA_W              = 8;
  // sleep entry delay in clock edges after first high sample
  localparam int unsigned SLEEP_ENTRY_CYCLES  = 2;
  // recovery time in ns and its cycle count, rounded up
  localparam int unsigned SLEEP_RECOVERY_NS   = 20;
  localparam int unsigned SLEEP_RECOVERY_CYC  =
    (SLEEP_RECOVERY_NS * REF_CLK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W               = 4;
  localparam logic [CNT_W-1:0] CNT_RESET      = 4'h0;
  // command codes on the link
  typedef enum logic [1:0] {
    SSLP_CMD_DESELECT = 2'h0,
    SSLP_CMD_READ     = 2'h1,
    SSLP_CMD_WRITE    = 2'h2,
    SSLP_CMD_DUMMY    = 2'h3
  } sslp_cmd_e;
  // device power states
  typedef enum logic [2:0] {
    SSLP_ST_AWAKE    = 3'h1,
    SSLP_ST_ENTERING = 3'h2,
    SSLP_ST_ASLEEP   = 3'h4
  } sslp_pwr_e;
  // controller states
  typedef enum logic [3:0] {
    SSLP_C_RUN     = 4'h1,
    SSLP_C_DRAIN   = 4'h2,
    SSLP_C_SLEEP   = 4'h4,
    SSLP_C_RECOVER = 4'h8
  } sslp_ctl_e;
endpackage : sslp_pkg

// ===== verilog/sslp_if.sv
// link between memory controller and sram sleep logic
interface sslp_if import sslp_pkg::*; ();
  logic                sleep_request;  // active high, pulled low if undriven
  logic                sleep_drive;    // controller drives sleep_request
  sslp_cmd_e           cmd;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wdata;
  logic [DATA_W-1:0]   dq_out;
  logic                dq_oe;          // high while the sram drives data
  // internal pull-down when the controller leaves the pin floating
  assign sleep_request = sleep_drive ? 1'b1 : 1'b0;
  modport sram (input sleep_request, cmd, addr, wdata,
                output dq_out, dq_oe);
  modport ctrl (output sleep_drive, cmd, addr, wdata,
                input dq_out, dq_oe);
endinterface : sslp_if

// ===== verilog/sslp_sram.sv
// sram end: storage, pipelined read and sleep power control
module sslp_sram
  import sslp_pkg::*;
#(
  parameter int unsigned DEPTH = 16
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // link
  sslp_if.sram             link,
  // status
  output logic             asleep,
  output logic             standby_current_level
);
  logic [DATA_W-1:0] mem [DEPTH];
  logic              req_s1;
  logic              req_s2;
  logic [1:0]        entry_cnt;
  sslp_pwr_e         pwr;
  logic              rd_pend;
  logic [ADDR_W-1:0] rd_addr;
  logic              active;

  // sleep request is asynchronous, two flops before use
  always_ff @(posedge ref_clk) begin
    req_s1 <= link.sleep_request;
    req_s2 <= req_s1;
  end

  assign active = (pwr != SSLP_ST_ASLEEP);

  // power state: entry after two edges, exit at once on low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pwr       <= SSLP_ST_AWAKE;
      entry_cnt <= 2'h0;
    end else begin
      unique case (pwr)
        SSLP_ST_AWAKE: begin
          if (req_s2) begin
            pwr       <= SSLP_ST_ENTERING;
            entry_cnt <= 2'h1;
          end
        end
        SSLP_ST_ENTERING: begin
          if (!req_s2) begin
            pwr <= SSLP_ST_AWAKE;
          end else if (entry_cnt == 2'(SLEEP_ENTRY_CYCLES - 1)) begin
            pwr <= SSLP_ST_ASLEEP;
          end else begin
            entry_cnt <= entry_cnt + 2'h1;
          end
        end
        SSLP_ST_ASLEEP: begin
          if (!req_s2) begin
            pwr <= SSLP_ST_AWAKE;
          end
        end
      endcase
    end
  end

  // writes store unless asleep (awake or entering); array has no reset, so asleep keeps it
  always_ff @(posedge ref_clk) begin
    if (active && link.cmd == SSLP_CMD_WRITE) begin
      mem[link.addr] <= link.wdata;
    end
  end

  // read pipeline: capture stage, then drive stage
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_pend <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_pend <= active && (link.cmd == SSLP_CMD_READ);
      rd_addr <= link.addr;
    end
  end

  // single cycle deselect: outputs off right after deselect is captured;
  // dummy reads leave rd_pend low and never drive the bus
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.dq_oe  <= 1'b0;
      link.dq_out <= '0;
    end else begin
      link.dq_oe  <= rd_pend && active;
      link.dq_out <= mem[rd_addr];
    end
  end

  // status flags
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      asleep                <= 1'b0;
      standby_current_level <= 1'b0;
    end else begin
      asleep                <= (pwr == SSLP_ST_ASLEEP);
      standby_current_level <= (pwr == SSLP_ST_ASLEEP);
    end
  end
endmodule : sslp_sram

// ===== verilog/sslp_ctrl.sv
// controller end: command issue, sleep sequencing and recovery
module sslp_ctrl
  import sslp_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // user side
  input  wire logic              sleep_want,
  input  wire logic              req_valid,
  input  wire logic              req_write,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [DATA_W-1:0] req_wdata,
  output logic                   req_ready,
  output logic                   rdata_valid,
  output logic [DATA_W-1:0]      rdata,
  output logic                   in_sleep,
  // link
  sslp_if.ctrl                   link
);
  sslp_ctl_e        st;
  logic [CNT_W-1:0] cnt;
  logic [1:0]       rd_track;
  logic             last_read;
  logic             can_issue;
  logic             need_dummy;
  logic             take;

  // writes barred until recovery count expires
  assign can_issue  = (st == SSLP_C_RUN) && !sleep_want;
  assign need_dummy = req_write && last_read;
  // a request counts as taken only when its own command goes out;
  // a write that first needs a dummy read is taken one edge later
  assign take = req_valid &&
                (req_write ? (can_issue && !need_dummy)
                           : (can_issue || st == SSLP_C_RECOVER));

  // sleep sequencing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st  <= SSLP_C_RUN;
      cnt <= CNT_RESET;
    end else begin
      unique case (st)
        SSLP_C_RUN: begin
          if (sleep_want) begin
            st <= SSLP_C_DRAIN;
          end
        end
        SSLP_C_DRAIN: begin
          if (rd_track == 2'h0) begin
            st <= SSLP_C_SLEEP;
          end
        end
        SSLP_C_SLEEP: begin
          if (!sleep_want) begin
            st  <= SSLP_C_RECOVER;
            cnt <= CNT_W'(SLEEP_RECOVERY_CYC);
          end
        end
        SSLP_C_RECOVER: begin
          if (cnt == CNT_RESET) begin
            st <= SSLP_C_RUN;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
      endcase
    end
  end

  // pin drive: high only when asleep; released pin falls to pull-down
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.sleep_drive <= 1'b0;
    end else begin
      link.sleep_drive <= (st == SSLP_C_SLEEP) && sleep_want;
    end
  end

  // command issue; during recovery only reads or deselects go out
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      link.cmd   <= SSLP_CMD_DESELECT;
      link.addr  <= '0;
      link.wdata <= '0;
      last_read  <= 1'b0;
    end else begin
      link.cmd <= SSLP_CMD_DESELECT;
      if (req_valid && !req_write &&
          (can_issue || st == SSLP_C_RECOVER)) begin
        link.cmd  <= SSLP_CMD_READ;
        link.addr <= req_addr;
        last_read <= 1'b1;
      end else if (req_valid && req_write && can_issue) begin
        if (need_dummy) begin
          link.cmd  <= SSLP_CMD_DUMMY;
          last_read <= 1'b0;
        end else begin
          link.cmd   <= SSLP_CMD_WRITE;
          link.addr  <= req_addr;
          link.wdata <= req_wdata;
        end
      end else begin
        last_read <= 1'b0;
      end
    end
  end

  // accept strobe mirrors the issue decision
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= take;
    end
  end

  // read tracking: data returns three edges after request is taken
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_track    <= 2'h0;
      rdata_valid <= 1'b0;
      rdata       <= '0;
      in_sleep    <= 1'b0;
    end else begin
      rd_track    <= {rd_track[0], link.cmd == SSLP_CMD_READ};
      rdata_valid <= link.dq_oe;
      rdata       <= link.dq_out;
      in_sleep    <= (st == SSLP_C_SLEEP);
    end
  end
endmodule : sslp_ctrl

// ===== tb/sslp_properties.sv
// concurrent checks on the sleep link between controller and sram
module sslp_properties
  import sslp_pkg::*;
(
  // clock and reset
  input wire logic      ref_clk,
  input wire logic      rst,
  // link
  input wire logic      sleep_request,
  input wire logic      sleep_drive,
  input wire sslp_cmd_e cmd,
  input wire logic      dq_oe
);
  logic [3:0] quiet;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // awake cycles since release; reads are judged only once recovery is over
  always_ff @(posedge ref_clk) begin
    if (rst || sleep_request) quiet <= 4'h0;
    else if (quiet != 4'hF) quiet <= quiet + 4'h1;
  end

  a_pin_pulled_low:
    assert property (sleep_request == sleep_drive)
    else $error("sleep pin differs from controller drive");
  a_silent_in_sleep:
    assert property (sleep_request [*8] |-> !dq_oe)
    else $error("data driven while asleep");
  a_idle_at_entry:
    assert property ($rose(sleep_request) |-> !dq_oe)
    else $error("sleep raised with a read in flight");
  a_asleep_no_write:
    assert property (sleep_request |-> cmd != SSLP_CMD_WRITE)
    else $error("write issued while sleep requested");
  a_recover_no_write:
    assert property ($fell(sleep_request) |-> (cmd != SSLP_CMD_WRITE) [*4])
    else $error("write issued during recovery");
  a_awake_read_drives:
    assert property (cmd == SSLP_CMD_READ && quiet > 4'h7 |-> ##2 dq_oe)
    else $error("awake read not answered");
  a_dummy_read_silent:
    assert property (cmd == SSLP_CMD_DUMMY |-> ##2 !dq_oe)
    else $error("dummy read drove data");
  a_no_read_write:
    assert property (cmd == SSLP_CMD_READ |=> cmd != SSLP_CMD_WRITE)
    else $error("write directly after read");
  a_oe_from_read:
    assert property ($rose(dq_oe) |-> $past(cmd, 2) == SSLP_CMD_READ)
    else $error("data driven without a read");

  c_sleep_enter: cover property ($rose(sleep_request));
  c_sleep_leave: cover property ($fell(sleep_request));
  c_dummy_read:  cover property (cmd == SSLP_CMD_DUMMY);
  c_read_beat:   cover property (dq_oe);
endmodule : sslp_properties

// ===== tb/sram_sleep_mode_control_tb.sv
// testbench joining controller and sram through the sleep link
module sram_sleep_mode_control_tb
  import sslp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              sleep_want = 1'b0;
  logic              req_valid = 1'b0;
  logic              req_write = 1'b0;
  logic [ADDR_W-1:0] req_addr = 4'h0;
  logic [DATA_W-1:0] req_wdata = 8'h00;
  logic              req_ready, rdata_valid, in_sleep, asleep, stby;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] exp_q[$];
  int                error_cnt = 0;
  int                total_checks = 0;
  int                n;

  sslp_if link ();
  always #2.5 ref_clk = ~ref_clk;

  sslp_sram u_sslp_sram (.ref_clk(ref_clk), .rst(rst), .link(link.sram),
    .asleep(asleep), .standby_current_level(stby));
  sslp_ctrl u_sslp_ctrl (.ref_clk(ref_clk), .rst(rst),
    .sleep_want(sleep_want), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rdata_valid(rdata_valid), .rdata(rdata), .in_sleep(in_sleep),
    .link(link.ctrl));
  sslp_properties u_sslp_properties (.ref_clk(ref_clk), .rst(rst),
    .sleep_request(link.sleep_request), .sleep_drive(link.sleep_drive),
    .cmd(link.cmd), .dq_oe(link.dq_oe));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  // read beats pair with queued expectations in issue order
  always @(posedge ref_clk) begin
    if (rdata_valid === 1'b1) begin
      if (exp_q.size() == 0) error_cnt++;
      else check(rdata, exp_q.pop_front());
    end
  end

  // request held for hold edges; writes held two to ride over a dummy
  task automatic put(input logic w, input logic [3:0] a,
                     input logic [7:0] d, input int hold);
    req_valid <= 1'b1;
    req_write <= w;
    req_addr  <= a;
    req_wdata <= d;
    repeat (hold) @(posedge ref_clk);
  endtask : put

  task automatic idle(input int cyc);
    req_valid <= 1'b0;
    repeat (cyc) @(posedge ref_clk);
  endtask : idle

  task automatic rd(input logic [3:0] a, input logic [7:0] d);
    exp_q.push_back(d);
    put(1'b0, a, 8'h00, 1);
  endtask : rd

  // bounded wait on sleep pin (sel 0) or asleep flag (sel 1)
  task automatic wait_for(input int sel, input logic v, output int cyc);
    cyc = 0;
    while ((sel ? asleep : link.sleep_request) !== v) begin
      @(posedge ref_clk);
      cyc++;
      if (cyc > 40) begin
        error_cnt++;
        wrap_up();
      end
    end
  endtask : wait_for

  initial begin
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int i = 0; i < 4; i++) put(1'b1, i[3:0], 8'hA0 + 8'(i), 2);
    check(8'(req_ready), 8'h01);
    for (int i = 0; i < 4; i++) rd(i[3:0], 8'hA0 + 8'(i));
    put(1'b1, 4'h5, 8'h5A, 2);
    rd(4'h5, 8'h5A);
    idle(8);
    sleep_want <= 1'b1;
    wait_for(0, 1'b1, n);
    wait_for(1, 1'b1, n);
    check(8'(n), 8'(2 + SLEEP_ENTRY_CYCLES + 1));
    check(8'(stby), 8'h01);
    check(8'(in_sleep), 8'h01);
    put(1'b1, 4'h0, 8'hFF, 2);
    check(8'(req_ready), 8'h00);
    idle(20);
    check(8'(asleep), 8'h01);
    check(8'(link.dq_oe), 8'h00);
    sleep_want <= 1'b0;
    wait_for(1, 1'b0, n);
    rd(4'h0, 8'hA0);
    idle(10);
    put(1'b1, 4'h0, 8'h3C, 2);
    rd(4'h0, 8'h3C);
    idle(10);
    check(8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule : sram_sleep_mode_control_tb
